/* src/irq_flag_bank.v */
`default_nettype none
// =====================================================
// sticky flags: a set in the same cycle as a clear wins
module irq_flag_bank #(
    parameter WIDTH = 11
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // events and clears
    input wire [WIDTH-1:0] set_i,
    input wire [WIDTH-1:0] clear_i,
    // state
    output reg [WIDTH-1:0] flag_o
);
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flag_o <= {WIDTH{1'b0}};
        else
            flag_o <= (flag_o & ~clear_i) | set_i; // RL7
    end
endmodule // irq_flag_bank
`default_nettype wire

/* src/uart_irq_dma_regs.vh */
// Overview of operation
// [RL1] masked status register is read only; writes change nothing
// [RL2] masked status bit is raw state AND mask
// [RL3] after reset non-modem masked bits read zero; modem bits follow pins (here modem bits also read zero and set only on pin edges)
// [RL4] overrun 10, break 9, parity 8, framing 7, timeout 6, tx 5, rx 4
// [RL5] modem bits: set-ready 3, carrier 2, clear-to-send 1, ring 0
// [RL6] unused upper bits read zero in status, clear and dma registers
// [RL7] clear register write only; one clears interrupt, zero does nothing
// [RL8] clear bits use the same positions as status bits
// [RL9] dma control is read/write and resets to zero
// [RL10] dma control bit 0 enables receive dma requests
// [RL11] dma control bit 1 enables transmit dma requests
// [RL12] bit 2 blocks both receive requests while error interrupt is asserted
// [RL13] raw status reports each source before masking
// [RL14] mask bits set by one, cleared by zero, reset to zero
// [RL15] error interrupt is OR of masked overrun, break, parity, framing
`ifndef UART_IRQ_DMA_REGS_VH
`define UART_IRQ_DMA_REGS_VH
// =====================================================
// register offsets
`define RAW_STATUS_ADDR 4'h0
`define MASK_ADDR 4'h1
`define MASKED_STATUS_ADDR 4'h2
`define CLEAR_ADDR 4'h3
`define DMA_CONTROL_ADDR 4'h4
// =====================================================
// field positions
`define BIT_OVERRUN 10
`define BIT_BREAK 9
`define BIT_PARITY 8
`define BIT_FRAMING 7
`define BIT_RX_TIMEOUT 6
`define BIT_TX 5
`define BIT_RX 4
`define BIT_SET_READY 3
`define BIT_CARRIER 2
`define BIT_CLEAR_TO_SEND 1
`define BIT_RING 0
`define BIT_RX_DMA_ENABLE 0
`define BIT_TX_DMA_ENABLE 1
`define BIT_RX_DMA_STOP_ON_ERROR 2
// =====================================================
// reset values
`define MASK_RESET 11'h000
`define DMA_CONTROL_RESET 3'h0
`define IRQ_RESET 11'h000
`endif

/* src/uart_irq_status_clear_dma_ctrl.v */
`include "uart_irq_dma_regs.vh"
`default_nettype none
module uart_irq_status_clear_dma_ctrl (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // register port
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire write_i,
    input wire read_i,
    output reg [15:0] rdata_o,
    // interrupt events from the uart core, one-cycle pulses
    input wire overrun_irq_i,
    input wire break_irq_i,
    input wire parity_irq_i,
    input wire framing_irq_i,
    input wire rx_timeout_irq_i,
    input wire tx_irq_i,
    input wire rx_irq_i,
    // modem pins, asynchronous, active low
    input wire modem_set_ready_n_i,
    input wire modem_carrier_n_i,
    input wire modem_clear_to_send_n_i,
    input wire modem_ring_n_i,
    // dma requests from the fifo logic
    input wire rx_single_i,
    input wire rx_burst_i,
    input wire tx_single_i,
    input wire tx_burst_i,
    // dma request outputs
    output wire rx_dma_single_request_o,
    output wire rx_dma_burst_request_o,
    output wire tx_dma_single_request_o,
    output wire tx_dma_burst_request_o,
    // interrupt
    output wire irq_o
);
    // =====================================================
    // helpers: the index match serves the write strobes, the padding serves the read path
    // one-bit index match
    function addr_hit;
        input [3:0] addr;
        input [3:0] index;
        begin
            addr_hit = (addr == index);
        end
    endfunction
    // the 11 flag bits sit low in a 16-bit word; the rest read zero
    function [15:0] pad_status;
        input [10:0] value;
        begin
            pad_status = {5'h00, value}; // RL6
        end
    endfunction
    function [15:0] pad_dma;
        input [2:0] value;
        begin
            pad_dma = {13'h0000, value}; // RL6
        end
    endfunction
    // =====================================================
    // modem pins: two flip-flops, then one more stage for edge detection
    reg [3:0] modem_meta_r;
    reg [3:0] modem_sync_r;
    reg [3:0] modem_prev_r;
    reg modem_primed_r;
    wire [3:0] modem_pins;
    wire [3:0] modem_change;
    assign modem_pins = {modem_set_ready_n_i, modem_carrier_n_i,
                         modem_clear_to_send_n_i, modem_ring_n_i};
    // idle-high reset values, so leaving reset is not mistaken for an edge
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            modem_meta_r <= 4'hF;
            modem_sync_r <= 4'hF;
        end
        else
        begin
            modem_meta_r <= modem_pins;
            modem_sync_r <= modem_meta_r;
        end
    end
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            modem_prev_r <= 4'hF;
            modem_primed_r <= 1'b0;
        end
        else
        begin
            modem_prev_r <= modem_sync_r;
            modem_primed_r <= 1'b1;
        end
    end
    // changes are held off only in the first cycle after reset, while sync and prev still hold their reset values
    assign modem_change = modem_primed_r ? (modem_sync_r ^ modem_prev_r) : 4'h0; // RL3
    // =====================================================
    // modem interrupt sources
    // any edge on a pin raises its flag, in either direction
    wire set_ready_irq;
    wire carrier_irq;
    wire clear_to_send_irq;
    wire ring_irq;
    assign set_ready_irq = modem_change[3]; // RL5
    assign carrier_irq = modem_change[2]; // RL5
    assign clear_to_send_irq = modem_change[1]; // RL5
    assign ring_irq = modem_change[0]; // RL5
    // =====================================================
    // register state and write strobes
    reg [10:0] mask_r;
    reg [2:0] dma_control_r;
    wire write_mask;
    wire write_clear;
    wire write_dma;
    assign write_mask = write_i && addr_hit(addr_i, `MASK_ADDR); // RL14
    assign write_clear = write_i && addr_hit(addr_i, `CLEAR_ADDR); // RL7
    assign write_dma = write_i && addr_hit(addr_i, `DMA_CONTROL_ADDR); // RL9
    // =====================================================
    // clear bits; a zero in the written word leaves its flag alone
    wire overrun_clear;
    wire break_clear;
    wire parity_clear;
    wire framing_clear;
    wire rx_timeout_clear;
    wire tx_clear;
    wire rx_clear;
    wire set_ready_clear;
    wire carrier_clear;
    wire clear_to_send_clear;
    wire ring_clear;
    wire [10:0] clear_bits;
    assign overrun_clear = write_clear & wdata_i[`BIT_OVERRUN]; // RL8
    assign break_clear = write_clear & wdata_i[`BIT_BREAK]; // RL8
    assign parity_clear = write_clear & wdata_i[`BIT_PARITY]; // RL8
    assign framing_clear = write_clear & wdata_i[`BIT_FRAMING]; // RL8
    assign rx_timeout_clear = write_clear & wdata_i[`BIT_RX_TIMEOUT]; // RL8
    assign tx_clear = write_clear & wdata_i[`BIT_TX]; // RL8
    assign rx_clear = write_clear & wdata_i[`BIT_RX]; // RL8
    assign set_ready_clear = write_clear & wdata_i[`BIT_SET_READY]; // RL8
    assign carrier_clear = write_clear & wdata_i[`BIT_CARRIER]; // RL8
    assign clear_to_send_clear = write_clear & wdata_i[`BIT_CLEAR_TO_SEND]; // RL8
    assign ring_clear = write_clear & wdata_i[`BIT_RING]; // RL8
    assign clear_bits = {overrun_clear, break_clear, parity_clear, framing_clear, // RL7
                         rx_timeout_clear, tx_clear, rx_clear, set_ready_clear,
                         carrier_clear, clear_to_send_clear, ring_clear};
    // =====================================================
    // sticky raw flags; a new event beats a clear in the same cycle
    wire [10:0] events;
    wire [10:0] raw_status;
    assign events = {overrun_irq_i, break_irq_i, parity_irq_i, framing_irq_i, // RL4
                     rx_timeout_irq_i, tx_irq_i, rx_irq_i,
                     set_ready_irq, carrier_irq,
                     clear_to_send_irq, ring_irq}; // RL5
    irq_flag_bank #(
        .WIDTH(11)
    ) flags (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .set_i(events),
        .clear_i(clear_bits),
        .flag_o(raw_status) // RL13
    );
    // =====================================================
    // masked status, one named bit per source
    // modem bits read zero after reset and only follow pin edges
    wire [10:0] gated_status;
    wire overrun_masked;
    wire break_masked;
    wire parity_masked;
    wire framing_masked;
    wire rx_timeout_masked;
    wire tx_masked;
    wire rx_masked;
    wire set_ready_masked;
    wire carrier_masked;
    wire clear_to_send_masked;
    wire ring_masked;
    wire [10:0] masked_status;
    assign gated_status = raw_status & mask_r; // RL2
    assign overrun_masked = gated_status[`BIT_OVERRUN];
    assign break_masked = gated_status[`BIT_BREAK];
    assign parity_masked = gated_status[`BIT_PARITY];
    assign framing_masked = gated_status[`BIT_FRAMING];
    assign rx_timeout_masked = gated_status[`BIT_RX_TIMEOUT];
    assign tx_masked = gated_status[`BIT_TX];
    assign rx_masked = gated_status[`BIT_RX];
    assign set_ready_masked = gated_status[`BIT_SET_READY];
    assign carrier_masked = gated_status[`BIT_CARRIER];
    assign clear_to_send_masked = gated_status[`BIT_CLEAR_TO_SEND];
    assign ring_masked = gated_status[`BIT_RING];
    assign masked_status = {overrun_masked, break_masked, parity_masked, framing_masked, // RL4
                            rx_timeout_masked, tx_masked, rx_masked, set_ready_masked,
                            carrier_masked, clear_to_send_masked, ring_masked}; // RL5
    // =====================================================
    // error interrupt and the single interrupt line
    // the error line only sees sources that software has let through
    wire error_irq;
    assign error_irq = overrun_masked | break_masked | parity_masked | framing_masked; // RL15
    assign irq_o = |masked_status;
    // =====================================================
    // dma control fields
    wire rx_dma_enable;
    wire tx_dma_enable;
    wire rx_dma_stop_on_error;
    assign rx_dma_enable = dma_control_r[`BIT_RX_DMA_ENABLE]; // RL10
    assign tx_dma_enable = dma_control_r[`BIT_TX_DMA_ENABLE]; // RL11
    assign rx_dma_stop_on_error = dma_control_r[`BIT_RX_DMA_STOP_ON_ERROR]; // RL12
    // =====================================================
    // next values of the writable registers
    // defaults hold; a write to either status index changes nothing
    reg [10:0] mask_nxt;
    reg [2:0] dma_control_nxt;
    always @*
    begin
        mask_nxt = mask_r; // RL1
        dma_control_nxt = dma_control_r;
        if (write_mask)
        begin
            mask_nxt = wdata_i[10:0]; // RL14
        end
        if (write_dma)
        begin
            dma_control_nxt = wdata_i[2:0]; // RL9
        end
    end
    // =====================================================
    // register state
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mask_r <= `MASK_RESET; // RL14
            dma_control_r <= `DMA_CONTROL_RESET; // RL9
        end
        else
        begin
            mask_r <= mask_nxt;
            dma_control_r <= dma_control_nxt;
        end
    end
    // =====================================================
    // read data, registered, standing only in the cycle after the strobe
    reg [15:0] rdata_nxt;
    always @*
    begin
        rdata_nxt = 16'h0000;
        if (read_i)
        begin
            case (addr_i)
                `RAW_STATUS_ADDR:
                begin
                    rdata_nxt = pad_status(raw_status); // RL13
                end
                `MASK_ADDR:
                begin
                    rdata_nxt = pad_status(mask_r); // RL14
                end
                `MASKED_STATUS_ADDR:
                begin
                    rdata_nxt = pad_status(masked_status); // RL2
                end
                // write only, so software never sees the strobes it wrote
                `CLEAR_ADDR:
                begin
                    rdata_nxt = 16'h0000; // RL7
                end
                `DMA_CONTROL_ADDR:
                begin
                    rdata_nxt = pad_dma(dma_control_r); // RL9
                end
                default:
                begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 16'h0000;
        end
        else
        begin
            rdata_o <= rdata_nxt;
        end
    end
    // =====================================================
    // dma request gating; combinational so a request drops in the cycle
    // the error appears, at the cost of a path from the flags to the pins
    wire rx_blocked;
    wire rx_allow;
    wire tx_allow;
    assign rx_blocked = rx_dma_stop_on_error & error_irq; // RL12
    assign rx_allow = rx_dma_enable & ~rx_blocked; // RL10
    assign tx_allow = tx_dma_enable; // RL11
    assign rx_dma_single_request_o = rx_allow & rx_single_i; // RL12
    assign rx_dma_burst_request_o = rx_allow & rx_burst_i; // RL12
    assign tx_dma_single_request_o = tx_allow & tx_single_i; // RL11
    assign tx_dma_burst_request_o = tx_allow & tx_burst_i; // RL11
endmodule // uart_irq_status_clear_dma_ctrl
`default_nettype wire

/* testbench/dma_peer.sv */
`default_nettype none
// ==========
// fifo side: raw requests, registered as real fifo flags are
module dma_peer (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // wanted and raised requests
    input wire logic [3:0] want_i,
    output logic [3:0] raw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            raw_o <= 4'h0;
        else
            raw_o <= want_i;
endmodule // dma_peer
`default_nettype wire

/* testbench/irq_chk_asserts.sv */
`default_nettype none
// ==========
// register port and dma gating checks
module irq_chk (
    // clock, reset and register port
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [15:0] rdata_o,
    // dma requests
    input wire logic rx_single_i,
    input wire logic tx_single_i,
    input wire logic rx_dma_single_request_o,
    input wire logic tx_dma_single_request_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_dma_upper_zero: assert property ($past(read_i) && $past(addr_i) == 4'h4
        |-> rdata_o[15:3] == 13'h0000) else $error("dma upper bits set");
    a_stat_upper_zero: assert property ($past(read_i) && $past(addr_i) == 4'h2
        |-> rdata_o[15:11] == 5'h00) else $error("status upper bits set");
    a_clear_reads_zero: assert property ($past(read_i) && $past(addr_i) == 4'h3
        |-> rdata_o == 16'h0000) else $error("clear register readable");
    a_dma_read_back: assert property ((write_i && addr_i == 4'h4) ##1 !write_i
        ##1 (read_i && addr_i == 4'h4) |=> rdata_o == {13'h0000, $past(wdata_i[2:0], 3)})
        else $error("dma control readback wrong");
    // gates only: a single request may never appear without its raw source
    a_tx_req_gate: assert property (tx_dma_single_request_o |-> tx_single_i)
        else $error("tx request without source");
    a_rx_req_gate: assert property (rx_dma_single_request_o |-> rx_single_i)
        else $error("rx request without source");
    a_rx_req_off: assert property (write_i && addr_i == 4'h4 && !wdata_i[0]
        |=> !rx_dma_single_request_o) else $error("rx request while disabled");
    a_tx_req_off: assert property (write_i && addr_i == 4'h4 && !wdata_i[1]
        |=> !tx_dma_single_request_o) else $error("tx request while disabled");
    cover property (rx_dma_single_request_o);
    cover property (write_i && addr_i == 4'h3);
    cover property (read_i ##1 rdata_o != 16'h0000);
endmodule // irq_chk
bind uart_irq_status_clear_dma_ctrl irq_chk chk_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .write_i(write_i),
    .read_i(read_i),
    .rdata_o(rdata_o),
    .rx_single_i(rx_single_i),
    .tx_single_i(tx_single_i),
    .rx_dma_single_request_o(rx_dma_single_request_o),
    .tx_dma_single_request_o(tx_dma_single_request_o)
);
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
// ==========
// register sequences with expected values
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic [10:0] ev = 11'h000;
    logic [3:0] want = 4'hF;
    wire [15:0] rdata_o;
    wire [3:0] raw;
    wire [3:0] req;
    wire irq_o;
    int err_total = 0;
    int compares = 0;
    initial forever #5 clk_i = ~clk_i;
    dma_peer peer_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .want_i(want), .raw_o(raw));
    // modem pins idle high, so ev bits 3:0 pulse them low
    uart_irq_status_clear_dma_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .overrun_irq_i(ev[10]), .break_irq_i(ev[9]),
        .parity_irq_i(ev[8]), .framing_irq_i(ev[7]), .rx_timeout_irq_i(ev[6]),
        .tx_irq_i(ev[5]), .rx_irq_i(ev[4]), .modem_set_ready_n_i(~ev[3]),
        .modem_carrier_n_i(~ev[2]), .modem_clear_to_send_n_i(~ev[1]),
        .modem_ring_n_i(~ev[0]), .rx_single_i(raw[0]), .rx_burst_i(raw[1]),
        .tx_single_i(raw[2]), .tx_burst_i(raw[3]), .rx_dma_single_request_o(req[0]),
        .rx_dma_burst_request_o(req[1]), .tx_dma_single_request_o(req[2]),
        .tx_dma_burst_request_o(req[3]), .irq_o(irq_o));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic complete_run();
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(4'h4, 16'h0000);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_i);
            ev <= 11'h001 << i;
            @(posedge clk_i);
            ev <= 11'h000;
            repeat (5) @(posedge clk_i);
            rd(4'h0, 16'h0001 << i);
            rd(4'h2, 16'h0000);
            wr(4'h3, ~(16'h0001 << i));
            rd(4'h0, 16'h0001 << i);
            wr(4'h3, 16'h0001 << i);
            rd(4'h0, 16'h0000);
        end
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h07FF);
        @(posedge clk_i);
        ev <= 11'h080;
        @(posedge clk_i);
        ev <= 11'h000;
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'h0080);
        chk({11'h000, irq_o, req}, 16'h0010);
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h0007);
        chk({11'h000, irq_o, req}, 16'h001C);
        wr(4'h3, 16'h0080);
        chk({11'h000, irq_o, req}, 16'h000F);
        wr(4'h4, 16'h0002);
        chk({11'h000, irq_o, req}, 16'h000C);
        wr(4'h4, 16'h0001);
        rd(4'h4, 16'h0001);
        chk({11'h000, irq_o, req}, 16'h0003);
        @(posedge clk_i);
        want <= 4'h5;
        repeat (2) @(posedge clk_i);
        #1 chk({11'h000, irq_o, req}, 16'h0001);
        @(posedge clk_i);
        want <= 4'hA;
        repeat (2) @(posedge clk_i);
        #1 chk({11'h000, irq_o, req}, 16'h0002);
        rd(4'h3, 16'h0000);
        rd(4'h5, 16'h0000);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
